// [rtl/lfb_pkg.sv]
// Shared constants and types for the latched event flag bank
package lfb_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // Register offsets (serial frame address field)
   localparam logic [5:0] LFB_ADDR_WARN = 6'h1e; // controller_warning_flags
   localparam logic [5:0] LFB_ADDR_SERR = 6'h1f; // serial_error_flags
   localparam logic [5:0] LFB_ADDR_GND = 6'h20; // short_to_ground_flags
   localparam logic [5:0] LFB_ADDR_OV = 6'h21; // overvoltage_flags
   localparam logic [7:0] LFB_RESET_VAL = 8'h00; // All flags clear
   // Implemented bit masks, unused bits read zero
   localparam logic [7:0] LFB_MASK_WARN = 8'h08;
   localparam logic [7:0] LFB_MASK_SERR = 8'h7f;
   localparam logic [7:0] LFB_MASK_MON = 8'hd3;
   // Field positions
   localparam int LFB_BIT_WDMISS = 3;
   localparam int LFB_BIT_PAR = 0;
   localparam int LFB_BIT_LEN = 1;
   localparam int LFB_BIT_ADDR = 2;
   localparam int LFB_BIT_DUR = 3;
   localparam int LFB_BIT_LOCK = 4;
   localparam int LFB_BIT_DEVCTL = 5;
   localparam int LFB_BIT_REG2CTL = 6;
   localparam int LFB_BIT_EXT2 = 7;
   localparam int LFB_BIT_EXT1 = 6;
   localparam int LFB_BIT_BOOST = 4;
   localparam int LFB_BIT_STEP2 = 1;
   localparam int LFB_BIT_STEP1 = 0;
   // Summary flag positions
   localparam int LFB_SUM_MCU = 1;
   localparam int LFB_SUM_SPI = 2;
   localparam int LFB_SUM_MON = 3;
   ////////////////////////////////////////////////////////////////////////////
   // Frame layout: write flag, address, data, parity
   localparam logic [4:0] LFB_FRAME_BITS = 5'h10;
   localparam logic [4:0] LFB_CNT_MAX = 5'h1f;
   localparam int LFB_RW_BIT = 15;
   localparam int LFB_ADDR_MSB = 14;
   localparam int LFB_ADDR_LSB = 9;
   localparam int LFB_DATA_MSB = 8;
   localparam int LFB_DATA_LSB = 1;
   // Select low time limit
   localparam int LFB_DUR_MS = 2;
   localparam int LFB_CLK_HZ = 100_000_000;
   localparam int LFB_DUR_CYCLES = LFB_DUR_MS * (LFB_CLK_HZ / 1000);
   ////////////////////////////////////////////////////////////////////////////
   // Frame engine states
   typedef enum logic [1:0] {
      LFB_IDLE = 2'b00,
      LFB_SHIFT = 2'b01,
      LFB_STALL = 2'b10
   } lfb_state_t;
   // Monitor event group, one pulse per source
   typedef struct packed {
      logic ext2;
      logic ext1;
      logic boost;
      logic step2;
      logic step1;
   } lfb_mon_evt_t;
   // Register access protocol violations from other blocks
   typedef struct packed {
      logic reg2_ctrl;
      logic dev_ctrl;
      logic lock;
   } lfb_proto_evt_t;
endpackage

// [rtl/lfb_flag_bank.sv]
// Latched event flag bank with its 16-bit serial access engine
`timescale 1ns/1ps
module lfb_flag_bank
   import lfb_pkg::*;
#(
   parameter int DUR_CYCLES = LFB_DUR_CYCLES
) (
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic CSN,
   input wire logic SCLK,
   input wire logic SDI,
   output logic SDO,
   output logic SDO_OE,
   input wire logic WDOG_MISS,
   input wire lfb_proto_evt_t PROTO_EVT,
   input wire lfb_mon_evt_t GND_EVT,
   input wire lfb_mon_evt_t OV_EVT,
   output logic [7:0] SUMMARY_FLAGS
);
   // Duration counter wide enough to pass the limit without wrapping
   localparam int DW = $clog2(DUR_CYCLES + 2);
   localparam logic [DW-1:0] DUR_LIMIT = DW'(DUR_CYCLES);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   // Address belongs to this bank
   // Only four offsets answer; anything else is an address fault
   function automatic logic lfb_addr_ok(input logic [5:0] a);
      return (a == LFB_ADDR_WARN) || (a == LFB_ADDR_SERR) ||
             (a == LFB_ADDR_GND) || (a == LFB_ADDR_OV);
   endfunction

   // Monitor event group placed at its register positions
   function automatic logic [7:0] lfb_mon_map(input lfb_mon_evt_t e);
      logic [7:0] v;
      v = 8'h00;
      v[LFB_BIT_EXT2] = e.ext2;
      v[LFB_BIT_EXT1] = e.ext1;
      v[LFB_BIT_BOOST] = e.boost;
      v[LFB_BIT_STEP2] = e.step2;
      v[LFB_BIT_STEP1] = e.step1;
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Frame engine state
   lfb_state_t state, next_state; // Engine phase
   logic [4:0] bit_cnt, next_bit_cnt; // Saturating clock count
   logic [DW-1:0] dur_cnt, next_dur_cnt; // Cycles with select low
   logic [15:0] shift_in, next_shift_in; // Received frame
   logic [15:0] shift_out, next_shift_out; // Outgoing answer
   logic [15:0] resp, next_resp; // Answer for the next frame
   logic sclk_q, next_sclk_q; // Previous clock level
   logic oe, next_oe; // Data pin drive
   // Flag registers
   logic [7:0] warn, next_warn;
   logic [7:0] serr, next_serr;
   logic [7:0] gnd, next_gnd;
   logic [7:0] ov, next_ov;
   logic [7:0] sum, next_sum;
   // Per-frame results, single-cycle
   logic frame_end, len_bad, par_bad, addr_bad, dur_hit, wr_hit;
   logic [5:0] f_addr;
   logic [7:0] f_data, rdata;

   // Frame decode, valid only on frame_end
   always_comb begin
      f_addr = shift_in[LFB_ADDR_MSB:LFB_ADDR_LSB];
      f_data = shift_in[LFB_DATA_MSB:LFB_DATA_LSB];
      frame_end = (state == LFB_SHIFT) && CSN;
      len_bad = frame_end && (bit_cnt != LFB_FRAME_BITS);
      // Odd parity over the whole frame
      par_bad = frame_end && !len_bad && !(^shift_in);
      addr_bad = frame_end && !len_bad && !par_bad && !lfb_addr_ok(f_addr);
      // Writes only land from a frame that passed every check
      wr_hit = frame_end && !len_bad && !par_bad && !addr_bad && shift_in[LFB_RW_BIT];
      // Limit counts system cycles; a stalled master trips it too
      dur_hit = (state == LFB_SHIFT) && !CSN && (dur_cnt >= DUR_LIMIT);
      // Read mux, current flags; a same-cycle event shows next time
      case (f_addr)
         LFB_ADDR_WARN: rdata = warn;
         LFB_ADDR_SERR: rdata = serr;
         LFB_ADDR_GND: rdata = gnd;
         LFB_ADDR_OV: rdata = ov;
         default: rdata = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame engine next values
   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_dur_cnt = dur_cnt;
      next_shift_in = shift_in;
      next_shift_out = shift_out;
      next_resp = resp;
      // Clock level kept every cycle so no state misses an edge
      next_sclk_q = SCLK;
      next_oe = !CSN;
      case (state)
         // Wait for select; load the prepared answer
         LFB_IDLE: begin
            if (!CSN) begin
               next_state = LFB_SHIFT;
               next_bit_cnt = 5'h00;
               next_dur_cnt = DW'(1);
               next_shift_out = resp;
            end
         end
         // Shift in on rising clock, out on falling clock
         LFB_SHIFT: begin
            if (CSN) begin
               next_state = LFB_IDLE;
               if (!len_bad && !par_bad) begin
                  // Answer carries address, data and odd parity
                  next_resp = {1'b0, f_addr, rdata, ~(^{f_addr, rdata})};
               end
            end else if (dur_hit) begin
               // Overlong frame is dropped whole
               next_state = LFB_STALL;
            end else begin
               next_dur_cnt = dur_cnt + DW'(1);
               if (SCLK && !sclk_q) begin
                  next_shift_in = {shift_in[14:0], SDI};
                  if (bit_cnt != LFB_CNT_MAX) begin
                     next_bit_cnt = bit_cnt + 5'h01;
                  end
               end
               if (!SCLK && sclk_q) begin
                  next_shift_out = {shift_out[14:0], 1'b0};
               end
            end
         end
         // Ignore everything until select returns high
         LFB_STALL: begin
            if (CSN) begin
               next_state = LFB_IDLE;
            end
         end
         default: next_state = LFB_IDLE;
      endcase
   end

   // Frame engine registers
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         state <= LFB_IDLE;
         bit_cnt <= 5'h00;
         dur_cnt <= '0;
         shift_in <= 16'h0000;
         shift_out <= 16'h0000;
         resp <= 16'h0000;
         sclk_q <= 1'b0;
         oe <= 1'b0;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         dur_cnt <= next_dur_cnt;
         shift_in <= next_shift_in;
         shift_out <= next_shift_out;
         resp <= next_resp;
         sclk_q <= next_sclk_q;
         oe <= next_oe;
      end
   end

   // Pins come straight from flops, no logic after the register
   assign SDO = shift_out[15];
   assign SDO_OE = oe;

   ////////////////////////////////////////////////////////////////////////////
   // Flag next values: set wins over clear so no event is lost
   always_comb begin
      logic [7:0] serr_set;
      logic [7:0] clr_warn, clr_serr, clr_gnd, clr_ov;
      // Only ones clear; zeros keep the flag
      clr_warn = (wr_hit && f_addr == LFB_ADDR_WARN) ? f_data : 8'h00;
      clr_serr = (wr_hit && f_addr == LFB_ADDR_SERR) ? f_data : 8'h00;
      clr_gnd = (wr_hit && f_addr == LFB_ADDR_GND) ? f_data : 8'h00;
      clr_ov = (wr_hit && f_addr == LFB_ADDR_OV) ? f_data : 8'h00;
      // Serial errors: link faults from here, access faults from other blocks
      serr_set = 8'h00;
      serr_set[LFB_BIT_PAR] = par_bad;
      serr_set[LFB_BIT_LEN] = len_bad;
      serr_set[LFB_BIT_ADDR] = addr_bad;
      serr_set[LFB_BIT_DUR] = dur_hit;
      serr_set[LFB_BIT_LOCK] = PROTO_EVT.lock;
      serr_set[LFB_BIT_DEVCTL] = PROTO_EVT.dev_ctrl;
      serr_set[LFB_BIT_REG2CTL] = PROTO_EVT.reg2_ctrl;
      next_warn = warn & ~clr_warn;
      next_warn[LFB_BIT_WDMISS] = next_warn[LFB_BIT_WDMISS] | WDOG_MISS;
      next_warn = next_warn & LFB_MASK_WARN;
      next_serr = ((serr & ~clr_serr) | serr_set) & LFB_MASK_SERR;
      next_gnd = ((gnd & ~clr_gnd) | lfb_mon_map(GND_EVT)) & LFB_MASK_MON;
      next_ov = ((ov & ~clr_ov) | lfb_mon_map(OV_EVT)) & LFB_MASK_MON;
      // Summary follows the flags one cycle later
      next_sum = 8'h00;
      next_sum[LFB_SUM_MCU] = |warn;
      next_sum[LFB_SUM_SPI] = |serr;
      next_sum[LFB_SUM_MON] = |(gnd | ov);
   end

   // Flag registers
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         warn <= LFB_RESET_VAL;
         serr <= LFB_RESET_VAL;
         gnd <= LFB_RESET_VAL;
         ov <= LFB_RESET_VAL;
         sum <= LFB_RESET_VAL;
      end else begin
         warn <= next_warn;
         serr <= next_serr;
         gnd <= next_gnd;
         ov <= next_ov;
         sum <= next_sum;
      end
   end

   // Summary lags its flags by one cycle, too short for software to notice
   assign SUMMARY_FLAGS = sum;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   // All checks sample on the system clock; all but a_reset_clear sleep while in reset
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RSTN);

   // Event capture and sticky behaviour
   a_wdog_latch: assert property (WDOG_MISS |=> warn[LFB_BIT_WDMISS])
      else $error("watchdog miss not latched");
   a_flag_sticky: assert property (warn[LFB_BIT_WDMISS] &&
      !(wr_hit && f_addr == LFB_ADDR_WARN && f_data[LFB_BIT_WDMISS])
      |=> warn[LFB_BIT_WDMISS])
      else $error("flag dropped without a clear");
   a_zero_write: assert property (wr_hit && f_addr == LFB_ADDR_SERR
      && !f_data[LFB_BIT_LEN] && serr[LFB_BIT_LEN] |=> serr[LFB_BIT_LEN])
      else $error("zero write changed a flag");
   a_reset_clear: assert property (@(posedge MCLK) disable iff (1'b0)
      !RSTN |-> (warn == 8'h00 && serr == 8'h00 && gnd == 8'h00 && ov == 8'h00))
      else $error("flags not clear in reset");
   a_ov_clear: assert property (wr_hit && f_addr == LFB_ADDR_OV && f_data[LFB_BIT_STEP1]
      && !OV_EVT.step1 |=> !ov[LFB_BIT_STEP1])
      else $error("written one did not clear the flag");
   // Serial error detection: link faults from here, access faults from other blocks
   a_dur_flag: assert property (state == LFB_SHIFT && !CSN && dur_cnt >= DUR_LIMIT
      |=> serr[LFB_BIT_DUR] && state == LFB_STALL)
      else $error("select duration error missed");
   a_len_flag: assert property (frame_end && bit_cnt != 5'h10 |=> serr[LFB_BIT_LEN])
      else $error("frame length error missed");
   a_par_flag: assert property (frame_end && bit_cnt == 5'h10 && !(^shift_in)
      |=> serr[LFB_BIT_PAR])
      else $error("parity error missed");
   a_addr_flag: assert property (frame_end && bit_cnt == 5'h10 && (^shift_in) &&
      !lfb_addr_ok(shift_in[14:9]) |=> serr[LFB_BIT_ADDR])
      else $error("invalid address not flagged");
   a_proto_flags: assert property (|PROTO_EVT
      |=> (serr[6:4] & $past(PROTO_EVT)) == $past(PROTO_EVT))
      else $error("protocol error not latched");
   // Monitor groups and summary
   a_gnd_flags: assert property (GND_EVT.ext2 ##1 1'b1
      |-> gnd[7] ##1 SUMMARY_FLAGS[3])
      else $error("ground short flag or summary missing");
   a_ov_flags: assert property (OV_EVT.step1 |=> ov[0])
      else $error("overvoltage flag missing");
   a_unused_zero: assert property (serr[7] == 1'b0 &&
      ((gnd | ov) & 8'h2c) == 8'h00 && (warn & 8'hf7) == 8'h00)
      else $error("unused bit set");
   a_summary_spi: assert property (|serr |=> SUMMARY_FLAGS[2])
      else $error("serial summary not raised");
   a_summary_mcu: assert property (|warn |=> SUMMARY_FLAGS[1])
      else $error("warning summary not raised");
   a_set_wins: assert property (WDOG_MISS && wr_hit && f_addr == LFB_ADDR_WARN &&
      f_data[LFB_BIT_WDMISS] |=> warn[LFB_BIT_WDMISS])
      else $error("event lost to a clear");

   // Main scenarios worth seeing
   c_write_clear: cover property (wr_hit ##1 serr == 8'h00);
   c_dur_abort: cover property (dur_hit ##[1:20] state == LFB_IDLE);
   c_set_race: cover property (WDOG_MISS && wr_hit && f_addr == LFB_ADDR_WARN);
   c_good_read: cover property (frame_end && !len_bad && !par_bad && !addr_bad &&
      !shift_in[LFB_RW_BIT]);
endmodule

// [bench/lfb_spi_master.sv]
// Serial master model that frames 16-bit words towards the flag bank
`timescale 1ns/1ps
module lfb_spi_master
   import lfb_pkg::*;
(
   input wire logic MCLK,
   output logic CSN,
   output logic SCLK,
   output logic SDI,
   input wire logic SDO
);
   ////////////////////////////////////////////////////////////////////////////
   // Idle: deselected, clock parked low
   initial begin
      CSN = 1'b1;
      SCLK = 1'b0;
      SDI = 1'b0;
   end
   // Word with odd parity over all 16 bits
   function automatic logic [15:0] mk(input logic rw, input logic [5:0] a, input logic [7:0] d);
      mk = {rw, a, d, 1'b0};
      mk[0] = ~^mk[15:1];
   endfunction
   // One frame of nbits clocks; short counts provoke a length fault
   task automatic frame(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
      rx = 16'h0000;
      @(posedge MCLK);
      #1 CSN = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         repeat (2) @(posedge MCLK);
         #1 rx = {rx[14:0], SDO};
         SDI = tx[15-i];
         SCLK = 1'b1;
         repeat (2) @(posedge MCLK);
         #1 SCLK = 1'b0;
      end
      repeat (2) @(posedge MCLK);
      #1 CSN = 1'b1;
      // Released line flips so a stale bit is never mistaken for data
      SDI = ~SDI;
      repeat (3) @(posedge MCLK);
      // Return off the edge so the caller never races the design
      #1;
   endtask
   // Select held low with no clocks, for the duration fault
   task automatic hold_low(input int n);
      @(posedge MCLK);
      #1 CSN = 1'b0;
      repeat (n) @(posedge MCLK);
      #1 CSN = 1'b1;
      repeat (3) @(posedge MCLK);
      #1;
   endtask
endmodule

// [bench/tb_latched_event_flag_bank.sv]
// Self-checking bench for the latched event flag bank
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
   $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module tb_latched_event_flag_bank
   import lfb_pkg::*;
;
   ////////////////////////////////////////////////////////////////////////////
   localparam int SELECT_DURATION_ERR = 100; // Above one frame's select time, still short
   logic mclk, rstn, wdog;
   wire logic csn, sclk, sdi, sdo;
   logic sdo_oe;
   lfb_proto_evt_t proto;
   lfb_mon_evt_t gnd, ov;
   logic [7:0] sum;
   int mismatches = 0;
   int checks_done = 0;
   // Bit a monitor source lands on, by struct position
   logic [7:0] pos [5] = '{8'h01, 8'h02, 8'h10, 8'h40, 8'h80};
   lfb_flag_bank #(.DUR_CYCLES(SELECT_DURATION_ERR)) u_lfb_flag_bank (.MCLK(mclk), .RSTN(rstn), .CSN(csn),
      .SCLK(sclk), .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe), .WDOG_MISS(wdog),
      .PROTO_EVT(proto), .GND_EVT(gnd), .OV_EVT(ov), .SUMMARY_FLAGS(sum));
   lfb_spi_master u_lfb_spi_master (.MCLK(mclk), .CSN(csn), .SCLK(sclk), .SDI(sdi), .SDO(sdo));
   ////////////////////////////////////////////////////////////////////////////
   // Clock, 10 ns period
   always #5 mclk = ~mclk;
   // Verdict and end of run
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Register write, write-one-to-clear
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [15:0] rx;
      u_lfb_spi_master.frame(u_lfb_spi_master.mk(1'b1, a, d), 16, rx);
   endtask
   // Answer lags one frame, so read twice and judge the second
   task automatic rd_chk(input logic [5:0] a, input logic [7:0] d);
      logic [15:0] rx;
      u_lfb_spi_master.frame(u_lfb_spi_master.mk(1'b0, a, 8'h00), 16, rx);
      u_lfb_spi_master.frame(u_lfb_spi_master.mk(1'b0, a, 8'h00), 16, rx);
      `CHK(rx, u_lfb_spi_master.mk(1'b0, a, d))
   endtask
   // Settle three edges after a one-cycle event pulse
   task automatic settle();
      @(posedge mclk);
      #1 wdog = 1'b0;
      proto = '0;
      gnd = '0;
      ov = '0;
      repeat (3) @(posedge mclk);
      // Look off the edge, where outputs have settled
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      `CHK(sdo_oe, 1'b0)
      `CHK(sum, 8'h00)
      rd_chk(LFB_ADDR_WARN, 8'h00);
      rd_chk(LFB_ADDR_SERR, 8'h00);
      rd_chk(LFB_ADDR_GND, 8'h00);
      rd_chk(LFB_ADDR_OV, 8'h00);
   endtask
   task automatic t_watchdog();
      wdog = 1'b1;
      settle();
      `CHK(sum, 8'h02)
      rd_chk(LFB_ADDR_WARN, 8'h08);
      wr(LFB_ADDR_WARN, 8'h00);
      rd_chk(LFB_ADDR_WARN, 8'h08);
      wr(LFB_ADDR_WARN, 8'hff);
      rd_chk(LFB_ADDR_WARN, 8'h00);
      `CHK(sum, 8'h00)
   endtask
   // Walk each monitor source alone through both registers
   task automatic t_monitors();
      for (int i = 0; i < 5; i++) begin
         gnd = lfb_mon_evt_t'(5'h01 << i);
         ov = lfb_mon_evt_t'(5'h01 << i);
         settle();
         `CHK(sum, 8'h08)
         rd_chk(LFB_ADDR_GND, pos[i]);
         rd_chk(LFB_ADDR_OV, pos[i]);
         wr(LFB_ADDR_GND, 8'hff);
         wr(LFB_ADDR_OV, 8'hff);
         rd_chk(LFB_ADDR_OV, 8'h00);
      end
   endtask
   task automatic t_proto();
      for (int i = 0; i < 3; i++) begin
         proto = lfb_proto_evt_t'(3'h1 << i);
         settle();
         `CHK(sum, 8'h04)
         rd_chk(LFB_ADDR_SERR, 8'h10 << i);
         wr(LFB_ADDR_SERR, 8'hff);
      end
   endtask
   // Short frame, bad parity and unknown address, back to back
   task automatic t_serial_err();
      logic [15:0] rx;
      u_lfb_spi_master.frame(u_lfb_spi_master.mk(1'b0, LFB_ADDR_WARN, 8'h00), 15, rx);
      u_lfb_spi_master.frame(u_lfb_spi_master.mk(1'b0, LFB_ADDR_WARN, 8'h00) ^ 16'h0001, 16, rx);
      u_lfb_spi_master.frame(u_lfb_spi_master.mk(1'b0, 6'h05, 8'h00), 16, rx);
      `CHK(sum, 8'h04)
      rd_chk(LFB_ADDR_SERR, 8'h07);
      wr(LFB_ADDR_SERR, 8'hfd);
      rd_chk(LFB_ADDR_SERR, 8'h02);
      wr(LFB_ADDR_SERR, 8'hff);
   endtask
   task automatic t_duration();
      u_lfb_spi_master.hold_low(SELECT_DURATION_ERR + 10);
      rd_chk(LFB_ADDR_SERR, 8'h08);
      wr(LFB_ADDR_SERR, 8'hff);
   endtask
   // Event lands two edges after the edge that applies a clear
   task automatic t_race();
      wdog = 1'b1;
      settle();
      fork
         wr(LFB_ADDR_WARN, 8'h08);
         begin
            // Select rises 67 edges into a full frame; the event is raised two edges later
            repeat (69) @(posedge mclk);
            #1 wdog = 1'b1;
            @(posedge mclk);
            #1 wdog = 1'b0;
         end
      join
      rd_chk(LFB_ADDR_WARN, 8'h08);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Hang guard: a run this long means something stalled
   initial begin
      repeat (40000) @(posedge mclk);
      mismatches++;
      wrap_up();
   end
   // Main sequence
   initial begin
      mclk = 1'b0;
      rstn = 1'b0;
      wdog = 1'b0;
      proto = '0;
      gnd = '0;
      ov = '0;
      repeat (4) @(posedge mclk);
      #1 rstn = 1'b1;
      t_reset();
      t_watchdog();
      t_monitors();
      t_proto();
      t_serial_err();
      t_duration();
      t_race();
      wrap_up();
   end
endmodule
